/* hdl/scc_top.v */
// System clock select and control: source, PLL path, divider, sleep modes.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.vh"
module scc_top (
   // Clock and reset.
   input wire clk_i,
   input wire rst_b_i,
   // Register port.
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // Oscillator and PLL pins.
   input wire main_osc_i,
   input wire int_osc_i,
   input wire ext32_osc_i,
   input wire pll_clk_i,
   input wire pll_locked_i,
   input wire hib_enabled_i,
   // Same-domain inputs.
   input wire [1:0] adc_rate_limit_i,
   input wire [7:0] wake_irq_i,
   // Oscillator and PLL controls.
   output reg main_osc_en_o,
   output reg int_osc_en_o,
   output reg pll_en_o,
   output reg [4:0] crystal_frequency_setting_o,
   // Clock enables and ADC rate.
   output reg cpu_clk_en_o,
   output reg [7:0] periph_clk_en_o,
   output reg pwm_clk_en_o,
   output reg [1:0] adc_rate_o
);

////////////////////////////////////////////////////////////////////////////////
// Power state codes.
localparam ST_RUN = 3'b001;
localparam ST_SLEEP = 3'b010;
localparam ST_DEEP = 3'b100;

// True for sources derived from the internal oscillator.
function is_internal;
   input [2:0] src;
   begin
      is_internal = (src == `SCC_SRC_INT) || (src == `SCC_SRC_INT4) ||
                    (src == `SCC_SRC_INT30);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Synchronisers and rising edge detect of pin inputs.
wire [5:0] pin_raw;
wire [5:0] pin_s;
reg [5:0] pin_d1_q;
assign pin_raw = {hib_enabled_i, pll_locked_i, pll_clk_i, ext32_osc_i, int_osc_i, main_osc_i};
genvar gi;
generate
   for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      scc_sync u_sync (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .async_i(pin_raw[gi]),
         .sync_o(pin_s[gi])
      );
   end
endgenerate
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      pin_d1_q <= 6'h00;
   end else begin
      pin_d1_q <= pin_s;
   end
end
wire [5:0] pin_rise = pin_s & ~pin_d1_q;
wire main_tick = pin_rise[0];
wire int_tick = pin_rise[1];
wire ext_tick = pin_rise[2];
wire pll_tick = pin_rise[3];
wire lock_rise = pin_rise[4];
wire lock_lvl = pin_s[4];
wire hib_lvl = pin_s[5];

////////////////////////////////////////////////////////////////////////////////
// Register decode.
wire wr_cfg = wr_i && (addr_i == `SCC_OFF_CLK_CFG);
wire wr_st = wr_i && (addr_i == `SCC_OFF_STATUS);
wire wr_adc = wr_i && (addr_i == `SCC_OFF_ADC);
wire wr_pwr = wr_i && (addr_i == `SCC_OFF_PWR);
wire wr_dslp = wr_i && (addr_i == `SCC_OFF_DSLP);
wire wr_pwm = wr_i && (addr_i == `SCC_OFF_PWM_DIV);
wire [2:0] wsrc = wdata_i[`SCC_CFG_SRC_MSB:`SCC_CFG_SRC_LSB];
wire wsrc_ok = (wsrc <= `SCC_SRC_INT30) && ((wsrc != `SCC_SRC_EXT32) || hib_lvl);

// Requested configuration.
reg [5:0] div_pend_q;
reg pll_pend_q;
reg [2:0] src_pend_q;
reg int_off_q;
reg main_off_q;
reg [1:0] adc_req_q;
reg gate_en_q;
reg [7:0] dslp_mask_q;
reg [5:0] pwm_div_q;
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      div_pend_q <= `SCC_RST_DIV;
      pll_pend_q <= 1'b0;
      src_pend_q <= `SCC_RST_SRC;
      int_off_q <= 1'b0;
      main_off_q <= 1'b0;
      crystal_frequency_setting_o <= `SCC_RST_XTAL;
      adc_req_q <= `SCC_RST_ADC;
      gate_en_q <= 1'b0;
      dslp_mask_q <= `SCC_RST_DSLP;
      pwm_div_q <= `SCC_RST_PWM_DIV;
   end else begin
      if (wr_cfg) begin
         div_pend_q <= wdata_i[`SCC_CFG_DIV_MSB:`SCC_CFG_DIV_LSB];
         pll_pend_q <= wdata_i[`SCC_CFG_PLL_BIT];
         if (wsrc_ok) begin
            src_pend_q <= wsrc;
         end
         int_off_q <= wdata_i[`SCC_CFG_INT_OFF_BIT];
         main_off_q <= wdata_i[`SCC_CFG_MAIN_OFF_BIT];
         crystal_frequency_setting_o <= wdata_i[`SCC_CFG_XTAL_MSB:`SCC_CFG_XTAL_LSB];
      end
      if (wr_adc) begin
         adc_req_q <= wdata_i[1:0];
      end
      if (wr_pwr) begin
         gate_en_q <= wdata_i[`SCC_PWR_GATE_BIT];
      end
      if (wr_dslp) begin
         dslp_mask_q <= wdata_i[7:0];
      end
      if (wr_pwm) begin
         pwm_div_q <= wdata_i[5:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Internal oscillator pre-dividers.
reg [4:0] int4_cnt_q;
reg [4:0] int30_cnt_q;
wire int4_tick = int_tick && (int4_cnt_q == `SCC_INT4_LAST);
wire int30_tick = int_tick && (int30_cnt_q == `SCC_INT30_LAST);
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      int4_cnt_q <= 5'h00;
      int30_cnt_q <= 5'h00;
   end else if (int_tick) begin
      int4_cnt_q <= int4_tick ? 5'h00 : int4_cnt_q + 5'h01;
      int30_cnt_q <= int30_tick ? 5'h00 : int30_cnt_q + 5'h01;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Active configuration and source selection.
reg [5:0] div_act_q;
reg pll_act_q;
reg [2:0] src_act_q;
reg src_tick;
always @* begin
   case (src_act_q)
      `SCC_SRC_MAIN: src_tick = main_tick;
      `SCC_SRC_INT: src_tick = int_tick;
      `SCC_SRC_INT4: src_tick = int4_tick;
      `SCC_SRC_EXT32: src_tick = ext_tick;
      `SCC_SRC_INT30: src_tick = int30_tick;
      default: src_tick = main_tick;
   endcase
end
wire path_tick = pll_act_q ? pll_tick : src_tick;
wire sys_tick;
scc_clk_div u_sys_div (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .tick_i(path_tick),
   .ratio_m1_i(div_act_q),
   .tick_o(sys_tick)
);
wire apply = sys_tick && (!pll_pend_q || lock_lvl);
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      div_act_q <= `SCC_RST_DIV;
      pll_act_q <= 1'b0;
      src_act_q <= `SCC_RST_SRC;
   end else if (apply) begin
      div_act_q <= div_pend_q;
      pll_act_q <= pll_pend_q;
      src_act_q <= src_pend_q;
   end
end

// Oscillator enables: the one clocking the device cannot be turned off.
wire main_in_use = (src_act_q == `SCC_SRC_MAIN) || pll_act_q || pll_pend_q;
wire int_in_use = is_internal(src_act_q) || is_internal(src_pend_q);
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      main_osc_en_o <= 1'b1;
      int_osc_en_o <= 1'b1;
      pll_en_o <= 1'b0;
   end else begin
      main_osc_en_o <= !main_off_q || main_in_use;
      int_osc_en_o <= !int_off_q || int_in_use;
      pll_en_o <= pll_pend_q || pll_act_q;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Lock flag: set wins over a write-one clear.
reg lock_flag_q;
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      lock_flag_q <= 1'b0;
   end else begin
      lock_flag_q <= lock_rise || (lock_flag_q && !(wr_st && wdata_i[`SCC_ST_LOCK_BIT]));
   end
end

////////////////////////////////////////////////////////////////////////////////
// Power state machine.
reg [2:0] pst_q;
reg [2:0] pst_d;
wire deep_wake = gate_en_q ? |(wake_irq_i & dslp_mask_q) : |wake_irq_i;
always @* begin
   pst_d = pst_q;
   case (pst_q)
      ST_RUN: begin
         if (wr_pwr && wdata_i[`SCC_PWR_DEEP_BIT]) begin
            pst_d = ST_DEEP;
         end else if (wr_pwr && wdata_i[`SCC_PWR_SLEEP_BIT]) begin
            pst_d = ST_SLEEP;
         end
      end
      ST_SLEEP: begin
         if (|wake_irq_i) begin
            pst_d = ST_RUN;
         end
      end
      ST_DEEP: begin
         if (deep_wake) begin
            pst_d = ST_RUN;
         end
      end
      default: pst_d = ST_RUN;
   endcase
end
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      pst_q <= ST_RUN;
   end else begin
      pst_q <= pst_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Clock enables to processor, peripherals and PWM.
wire pwm_tick;
scc_clk_div u_pwm_div (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .tick_i(sys_tick),
   .ratio_m1_i(pwm_div_q),
   .tick_o(pwm_tick)
);
wire [7:0] periph_keep = (pst_q == ST_DEEP && gate_en_q) ? dslp_mask_q : 8'hFF;
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 8'h00;
      pwm_clk_en_o <= 1'b0;
   end else begin
      cpu_clk_en_o <= sys_tick && (pst_q == ST_RUN);
      periph_clk_en_o <= {8{sys_tick}} & periph_keep;
      pwm_clk_en_o <= pwm_tick;
   end
end

////////////////////////////////////////////////////////////////////////////////
// ADC rate in use: the slower of request and hardware limit.
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      adc_rate_o <= `SCC_RST_ADC;
   end else begin
      adc_rate_o <= (adc_req_q > adc_rate_limit_i) ? adc_req_q : adc_rate_limit_i;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, valid only in the cycle after the read strobe.
reg [31:0] rd_mux;
always @* begin
   rd_mux = 32'h0000_0000;
   case (addr_i)
      `SCC_OFF_CLK_CFG: begin
         rd_mux[`SCC_CFG_DIV_MSB:`SCC_CFG_DIV_LSB] = div_pend_q;
         rd_mux[`SCC_CFG_PLL_BIT] = pll_pend_q;
         rd_mux[`SCC_CFG_SRC_MSB:`SCC_CFG_SRC_LSB] = src_pend_q;
         rd_mux[`SCC_CFG_INT_OFF_BIT] = int_off_q;
         rd_mux[`SCC_CFG_MAIN_OFF_BIT] = main_off_q;
         rd_mux[`SCC_CFG_XTAL_MSB:`SCC_CFG_XTAL_LSB] = crystal_frequency_setting_o;
      end
      `SCC_OFF_STATUS: begin
         rd_mux[`SCC_ST_LOCK_BIT] = lock_flag_q;
         rd_mux[`SCC_ST_PLL_ACT_BIT] = pll_act_q;
         rd_mux[`SCC_ST_SRC_LSB+2:`SCC_ST_SRC_LSB] = src_act_q;
         rd_mux[`SCC_ST_DIV_LSB+5:`SCC_ST_DIV_LSB] = div_act_q;
         rd_mux[`SCC_ST_INT_RUN_BIT] = int_osc_en_o;
         rd_mux[`SCC_ST_MAIN_RUN_BIT] = main_osc_en_o;
         rd_mux[`SCC_ST_SLEEP_BIT] = (pst_q == ST_SLEEP);
         rd_mux[`SCC_ST_DEEP_BIT] = (pst_q == ST_DEEP);
         rd_mux[`SCC_ST_LOCK_LVL_BIT] = lock_lvl;
      end
      `SCC_OFF_ADC: begin
         rd_mux[1:0] = adc_req_q;
         rd_mux[3:2] = adc_rate_o;
      end
      `SCC_OFF_PWR: rd_mux[`SCC_PWR_GATE_BIT] = gate_en_q;
      `SCC_OFF_DSLP: rd_mux[7:0] = dslp_mask_q;
      `SCC_OFF_PWM_DIV: rd_mux[5:0] = pwm_div_q;
      default: rd_mux = 32'h0000_0000;
   endcase
end
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
   end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
   end
end

endmodule // scc_top
`default_nettype wire

/* common/scc_defs.vh */
// Register offsets, field positions, reset values and codes of the system clock control.
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

`define SCC_ADDR_W 8
`define SCC_OFF_CLK_CFG 8'h00
`define SCC_OFF_STATUS 8'h04
`define SCC_OFF_ADC 8'h08
`define SCC_OFF_PWR 8'h0C
`define SCC_OFF_DSLP 8'h10
`define SCC_OFF_PWM_DIV 8'h14

`define SCC_CFG_DIV_LSB 0
`define SCC_CFG_DIV_MSB 5
`define SCC_CFG_PLL_BIT 6
`define SCC_CFG_SRC_LSB 7
`define SCC_CFG_SRC_MSB 9
`define SCC_CFG_INT_OFF_BIT 10
`define SCC_CFG_MAIN_OFF_BIT 11
`define SCC_CFG_XTAL_LSB 12
`define SCC_CFG_XTAL_MSB 16

`define SCC_ST_LOCK_BIT 0
`define SCC_ST_PLL_ACT_BIT 1
`define SCC_ST_SRC_LSB 2
`define SCC_ST_DIV_LSB 5
`define SCC_ST_INT_RUN_BIT 11
`define SCC_ST_MAIN_RUN_BIT 12
`define SCC_ST_SLEEP_BIT 13
`define SCC_ST_DEEP_BIT 14
`define SCC_ST_LOCK_LVL_BIT 15

`define SCC_PWR_SLEEP_BIT 0
`define SCC_PWR_DEEP_BIT 1
`define SCC_PWR_GATE_BIT 2

`define SCC_SRC_MAIN 3'h0
`define SCC_SRC_INT 3'h1
`define SCC_SRC_INT4 3'h2
`define SCC_SRC_EXT32 3'h3
`define SCC_SRC_INT30 3'h4

`define SCC_ADC_1MSPS 2'h0
`define SCC_ADC_500KSPS 2'h1
`define SCC_ADC_250KSPS 2'h2
`define SCC_ADC_125KSPS 2'h3

`define SCC_INT4_LAST 5'h03
`define SCC_INT30_LAST 5'h1D

`define SCC_RST_DIV 6'h00
`define SCC_RST_SRC 3'h0
`define SCC_RST_XTAL 5'h00
`define SCC_RST_ADC 2'h0
`define SCC_RST_DSLP 8'h00
`define SCC_RST_PWM_DIV 6'h00
`define SCC_NUM_PERIPH 8

`endif

/* hdl/scc_sync.v */
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module scc_sync (
   // Clock and reset.
   input wire clk_i,
   input wire rst_b_i,
   // Level in and synchronised level out.
   input wire async_i,
   output reg sync_o
);
reg meta_q;
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
   end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
   end
end
endmodule // scc_sync
`default_nettype wire

/* hdl/scc_clk_div.v */
// Tick divider with ratio 1 to 64; the ratio is taken only at a boundary.
`timescale 1ns/1ps
`default_nettype none
module scc_clk_div (
   // Clock and reset.
   input wire clk_i,
   input wire rst_b_i,
   // Input ticks and ratio minus one.
   input wire tick_i,
   input wire [5:0] ratio_m1_i,
   // Divided tick, one cycle long.
   output reg tick_o
);
reg [5:0] cnt_q;
reg [5:0] ratio_q;
always @(posedge clk_i or negedge rst_b_i) begin
   if (!rst_b_i) begin
      cnt_q <= 6'h00;
      ratio_q <= 6'h00;
      tick_o <= 1'b0;
   end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
         if (cnt_q >= ratio_q) begin
            cnt_q <= 6'h00;
            tick_o <= 1'b1;
            ratio_q <= ratio_m1_i;
         end else begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end
end
endmodule // scc_clk_div
`default_nettype wire

/* tb/scc_top_sva.sv */
// Concurrent checks on the ports of the system clock select and control.
`timescale 1ns/1ps
`default_nettype none
module scc_top_sva (
   // Clock and reset.
   input wire clk_i,
   input wire rst_b_i,
   // Register port and same-domain inputs.
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire [1:0] adc_rate_limit_i,
   input wire [7:0] wake_irq_i,
   // Outputs under check.
   input wire main_osc_en_o,
   input wire int_osc_en_o,
   input wire pll_en_o,
   input wire [4:0] crystal_frequency_setting_o,
   input wire cpu_clk_en_o,
   input wire [7:0] periph_clk_en_o,
   input wire [1:0] adc_rate_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   wire cfg_wr = wr_i && addr_i == 8'h00;
   wire pwr_wr = wr_i && addr_i == 8'h0C && wdata_i[1:0] != 2'h0;
   wire [4:0] wxtal = wdata_i[16:12];
   ////////////////////////////////////////////////////////////////
   property p_sleep_halt;
      pwr_wr ##1 (wake_irq_i == 8'h00) [*4] |-> !cpu_clk_en_o;
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) else $error("tick while asleep");
   property p_tick_single;
      cpu_clk_en_o |=> !cpu_clk_en_o;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick too long");
   property p_periph_run;
      cpu_clk_en_o |-> periph_clk_en_o == 8'hFF;
   endproperty
   a_periph_run: assert property (p_periph_run) else $error("periph rate");
   property p_adc_floor;
      $past(rst_b_i) |-> adc_rate_o >= $past(adc_rate_limit_i);
   endproperty
   a_adc_floor: assert property (p_adc_floor) else $error("adc above limit");
   property p_pll_power;
      cfg_wr && wdata_i[6] |-> ##[1:3] pll_en_o;
   endproperty
   a_pll_power: assert property (p_pll_power) else $error("pll not powered");
   property p_pll_main;
      cfg_wr && wdata_i[6] |-> ##[1:3] main_osc_en_o;
   endproperty
   a_pll_main: assert property (p_pll_main) else $error("main osc off");
   property p_int_kept;
      cfg_wr && wdata_i[9:7] inside {3'h1, 3'h2, 3'h4} |-> ##[1:3] int_osc_en_o;
   endproperty
   a_int_kept: assert property (p_int_kept) else $error("int osc off");
   property p_xtal_out;
      cfg_wr |=> crystal_frequency_setting_o == $past(wxtal);
   endproperty
   a_xtal_out: assert property (p_xtal_out) else $error("crystal setting");
   c_sleep: cover property (pwr_wr);
   c_pll: cover property (cfg_wr && wdata_i[6]);
   c_tick: cover property (cpu_clk_en_o ##[1:20] cpu_clk_en_o);
endmodule // scc_top_sva
bind scc_top scc_top_sva u_scc_top_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .adc_rate_limit_i(adc_rate_limit_i), .wake_irq_i(wake_irq_i),
   .main_osc_en_o(main_osc_en_o), .int_osc_en_o(int_osc_en_o), .pll_en_o(pll_en_o),
   .crystal_frequency_setting_o(crystal_frequency_setting_o), .cpu_clk_en_o(cpu_clk_en_o),
   .periph_clk_en_o(periph_clk_en_o), .adc_rate_o(adc_rate_o));
`default_nettype wire

/* tb/scc_top_tb.sv */
// Self-checking bench of the system clock select and control.
`timescale 1ns/1ps
`default_nettype none
module scc_top_tb;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic main_osc_i = 1'b0;
   logic int_osc_i = 1'b0;
   logic ext32_osc_i = 1'b0;
   logic pll_clk_i = 1'b0;
   logic pll_locked_i = 1'b0;
   logic hib_enabled_i = 1'b0;
   logic [1:0] adc_rate_limit_i = 2'h0;
   logic [7:0] wake_irq_i = 8'h00;
   wire [31:0] rdata_o;
   wire main_osc_en_o;
   wire int_osc_en_o;
   wire pll_en_o;
   wire [4:0] crystal_frequency_setting_o;
   wire cpu_clk_en_o;
   wire [7:0] periph_clk_en_o;
   wire pwm_clk_en_o;
   wire [1:0] adc_rate_o;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int i;
   int n;
   int d;
   int m;
   int prd [5] = '{8, 6, 24, 10, 180};
   logic rd_p = 1'b0;
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   logic [31:0] e;
   logic [31:0] k;
   scc_top u_scc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_osc_i(main_osc_i),
      .int_osc_i(int_osc_i), .ext32_osc_i(ext32_osc_i), .pll_clk_i(pll_clk_i),
      .pll_locked_i(pll_locked_i), .hib_enabled_i(hib_enabled_i),
      .adc_rate_limit_i(adc_rate_limit_i), .wake_irq_i(wake_irq_i),
      .main_osc_en_o(main_osc_en_o), .int_osc_en_o(int_osc_en_o), .pll_en_o(pll_en_o),
      .crystal_frequency_setting_o(crystal_frequency_setting_o), .cpu_clk_en_o(cpu_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o), .pwm_clk_en_o(pwm_clk_en_o), .adc_rate_o(adc_rate_o));
   ////////////////////////////////////////////////////////////////
   task finish_test;
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   function automatic logic pr(input int s);
      if (s == 0) return cpu_clk_en_o;
      if (s == 1) return pwm_clk_en_o;
      return periph_clk_en_o[s - 2];
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] x);
      exp_q.push_back(x);
      msk_q.push_back(msk);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Cycles from one pulse of the probe to the next, bounded.
   task automatic gap(input int s, output int q);
      int w;
      w = 0;
      @(negedge clk_i);
      while (pr(s) !== 1'b1 && w < 2000) begin
         @(negedge clk_i);
         w++;
      end
      q = 0;
      do begin
         @(negedge clk_i);
         q++;
      end while (pr(s) !== 1'b1 && q < 2000);
      @(posedge clk_i);
   endtask
   task automatic per(input int s, input int x);
      int g;
      gap(s, g);
      gap(s, g);
      chk(g, x);
   endtask
   task automatic cnt(input int s, input int c, output int q);
      q = 0;
      repeat (c) begin
         @(negedge clk_i);
         if (pr(s) === 1'b1) q++;
      end
      @(posedge clk_i);
   endtask
   task wake(input logic [7:0] v);
      wake_irq_i <= v;
      repeat (2) @(posedge clk_i);
      wake_irq_i <= 8'h00;
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////
   initial forever #10 clk_i = ~clk_i;
   // Source pins, bench cycle count and the read-data monitor.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) main_osc_i <= ~main_osc_i;
      if (cyc % 3 == 2) int_osc_i <= ~int_osc_i;
      if (cyc % 5 == 4) ext32_osc_i <= ~ext32_osc_i;
      if (cyc % 2 == 1) pll_clk_i <= ~pll_clk_i;
      rd_p <= rd_i;
      if (cyc == 60000) begin
         failures++;
         finish_test();
      end
   end
   always @(negedge clk_i) begin
      if (rd_p) begin
         e = exp_q.pop_front();
         k = msk_q.pop_front();
         chk(rdata_o & k, e);
      end else if (rdata_o !== 32'h0000_0000) begin
         chk(rdata_o, 32'h0000_0000);
      end
   end
   initial begin
      i = $urandom(39735);
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      chk(32'(main_osc_en_o), 1);
      chk(32'(pll_en_o), 0);
      rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
      hib_enabled_i <= 1'b1;
      for (i = 0; i < 5; i++) begin
         wr(8'h00, 32'(i) << 7);
         per(0, prd[i]);
      end
      hib_enabled_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr(8'h00, 32'h0000_0180);
      rd(8'h00, 32'h0000_0380, 32'h0000_0200);
      wr(8'h00, 32'h0000_0300);
      rd(8'h00, 32'h0000_0380, 32'h0000_0200);
      d = $urandom_range(62, 0);
      for (i = 0; i < 2; i++) begin
         wr(8'h00, 32'(d));
         per(0, 8 * (d + 1));
         d = 63;
      end
      wr(8'h00, 32'h0000_0000);
      wr(8'h14, 32'h0000_0002);
      per(1, 24);
      per(2 + $urandom_range(7, 0), 8);
      wr(8'h00, 32'h0000_0800);
      per(0, 8);
      chk(32'(main_osc_en_o), 1);
      wr(8'h00, 32'h0000_0C80);
      per(0, 6);
      chk(32'(main_osc_en_o), 0);
      chk(32'(int_osc_en_o), 1);
      wr(8'h00, 32'h0001_0040);
      per(0, 6);
      chk(32'(pll_en_o), 1);
      chk(32'(crystal_frequency_setting_o), 32'h0000_0010);
      rd(8'h04, 32'h0000_0001, 32'h0000_0000);
      pll_locked_i <= 1'b1;
      per(0, 4);
      rd(8'h04, 32'h0000_0003, 32'h0000_0003);
      wr(8'h04, 32'h0000_0001);
      rd(8'h04, 32'h0000_0001, 32'h0000_0000);
      wr(8'h00, 32'h0000_0000);
      for (i = 0; i < 4; i++) begin
         m = $urandom_range(3, 0);
         adc_rate_limit_i <= 2'(m);
         wr(8'h08, 32'(i));
         m = (m > i) ? m : i;
         rd(8'h08, 32'h0000_000F, 32'((m << 2) | i));
         chk(32'(adc_rate_o), 32'(m));
      end
      wr(8'h0C, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      cnt(0, 100, n);
      chk(n, 0);
      cnt(5, 100, n);
      chk(32'(n > 0), 1);
      wake(8'h04);
      per(0, 8);
      wr(8'h10, 32'h0000_0001);
      wr(8'h0C, 32'h0000_0006);
      repeat (2) @(posedge clk_i);
      wake(8'h02);
      cnt(3, 100, n);
      chk(n, 0);
      cnt(2, 100, n);
      chk(32'(n > 0), 1);
      cnt(0, 100, n);
      chk(n, 0);
      wake(8'h01);
      per(0, 8);
      wr(8'h0C, 32'h0000_0002);
      repeat (2) @(posedge clk_i);
      cnt(3, 100, n);
      chk(32'(n > 0), 1);
      wake(8'h80);
      per(0, 8);
      wr(8'h00, 32'h0000_0400);
      per(0, 8);
      chk(32'(int_osc_en_o), 0);
      finish_test();
   end
endmodule // scc_top_tb
`default_nettype wire
